// *** verilog/pcsmg_ctrl.sv ***
// PCS management, negotiation and test-mode control top
`timescale 1ns/1ps
`default_nettype none
module pcsmg_ctrl #(
    parameter int LINK_CYC = pcsmg_pkg::LINK_TIMER_CYC,
    parameter int FIFO_DEPTH = pcsmg_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Management
    input wire logic negotiation_enable_i,
    input wire logic pcs_main_reset_i,
    input wire logic negotiation_restart_i,
    input wire logic [15:0] local_ability_word_i,
    output logic negotiation_done_o,
    output logic [15:0] partner_ability_word_o,
    output logic page_received_o,
    output logic link_good_o,
    // Test modes
    input wire logic force_isolate_i,
    input wire logic force_loopback_i,
    input wire logic force_unidir_i,
    input wire logic debug_link_timer_short_i,
    // GMII transmit
    input wire logic [7:0] gmii_txd_i,
    input wire logic gmii_tx_en_i,
    input wire logic gmii_tx_er_i,
    output logic gmii_tx_ready_o,
    // GMII receive
    output logic [7:0] gmii_rxd_o,
    output logic gmii_rx_dv_o,
    output logic gmii_rx_er_o,
    // Code-group side
    output logic [7:0] tx_code_o,
    output logic tx_kcntl_o,
    input wire logic [7:0] rx_code_i,
    input wire logic rx_kcntl_i,
    input wire logic rx_cv_err_i,
    input wire logic signal_detect_i,
    output logic idle_insert_o
);
    // ==========================================================
    // Isolation and transmit FIFO
    logic [9:0] tx_word;
    logic [9:0] fifo_out;
    logic fifo_valid;
    logic fifo_pop;
    logic tx_accept;
    logic sm_rst;
    logic an_running;
    logic rx_sync_r;
    logic rx_bad;

    assign sm_rst = pcs_main_reset_i; // RULE_02
    // Isolate presents an all-zero GMII word to transmit
    assign tx_word = force_isolate_i ? 10'h000 : {gmii_tx_er_i, gmii_tx_en_i, gmii_txd_i}; // RULE_08
    assign rx_bad = !rx_sync_r || an_running;
    // FIFO data is only sent when transmit may use it; outside negotiation it is otherwise popped and dropped, during negotiation it is held
    assign tx_accept = force_unidir_i || !rx_bad; // RULE_12 RULE_13

    pcsmg_fifo #(
        .WIDTH(10),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .flush_i(sm_rst),
        .in_valid_i(1'b1),
        .in_ready_o(gmii_tx_ready_o),
        .in_data_i(tx_word),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_out)
    );

    // ==========================================================
    // Negotiation state machine
    pcsmg_pkg::pcsmg_an_e st_r;
    pcsmg_pkg::pcsmg_an_e st_nxt;
    logic tmr_start;
    logic tmr_done;
    logic [15:0] rx_word_r;
    logic [15:0] lp_word_r;
    logic rx_word_vld_r;
    logic [1:0] cfg_ph_r;

    pcsmg_link_timer #(
        .NORMAL_CYC(LINK_CYC),
        .DEBUG_CYC(pcsmg_pkg::DEBUG_TIMER_CYC)
    ) u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .start_i(tmr_start),
        .short_i(debug_link_timer_short_i),
        .done_o(tmr_done)
    );

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            pcsmg_pkg::PCSMG_AN_ENABLE: st_nxt = pcsmg_pkg::PCSMG_AN_RESTART;
            pcsmg_pkg::PCSMG_AN_RESTART: if (tmr_done) st_nxt = pcsmg_pkg::PCSMG_ABIL_DET;
            pcsmg_pkg::PCSMG_ABIL_DET: begin
                if (rx_word_vld_r && rx_word_r != 16'h0000) begin
                    st_nxt = pcsmg_pkg::PCSMG_ACK_DET;
                end
            end
            pcsmg_pkg::PCSMG_ACK_DET: begin
                if (rx_word_vld_r && rx_word_r[pcsmg_pkg::ACK_BIT]) begin
                    st_nxt = pcsmg_pkg::PCSMG_CMPL_ACK;
                end
            end
            pcsmg_pkg::PCSMG_CMPL_ACK: if (tmr_done) st_nxt = pcsmg_pkg::PCSMG_LINK_OK;
            pcsmg_pkg::PCSMG_LINK_OK: if (!rx_sync_r) st_nxt = pcsmg_pkg::PCSMG_AN_ENABLE;
            pcsmg_pkg::PCSMG_DIS_LINK_OK: st_nxt = pcsmg_pkg::PCSMG_DIS_LINK_OK;
            default: st_nxt = pcsmg_pkg::PCSMG_AN_ENABLE;
        endcase
        if (!negotiation_enable_i) begin
            st_nxt = pcsmg_pkg::PCSMG_DIS_LINK_OK; // RULE_01
        end else if (negotiation_restart_i || st_r == pcsmg_pkg::PCSMG_DIS_LINK_OK) begin
            st_nxt = pcsmg_pkg::PCSMG_AN_ENABLE; // RULE_03
        end
    end

    assign tmr_start = (st_nxt != st_r);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= pcsmg_pkg::PCSMG_AN_ENABLE; // RULE_16
        end else if (sm_rst) begin
            st_r <= pcsmg_pkg::PCSMG_AN_ENABLE; // RULE_02
        end else begin
            st_r <= st_nxt;
        end
    end

    assign an_running = negotiation_enable_i && !(st_r == pcsmg_pkg::PCSMG_LINK_OK);
    assign idle_insert_o = an_running && !sm_rst; // RULE_18
    assign page_received_o = (st_r == pcsmg_pkg::PCSMG_CMPL_ACK); // RULE_06
    assign link_good_o = negotiation_enable_i ? (st_r == pcsmg_pkg::PCSMG_LINK_OK) // RULE_14
        : (st_r == pcsmg_pkg::PCSMG_DIS_LINK_OK); // RULE_15

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            negotiation_done_o <= 1'b0;
        end else if (sm_rst || negotiation_restart_i || !negotiation_enable_i) begin
            negotiation_done_o <= 1'b0;
        end else if (st_r == pcsmg_pkg::PCSMG_LINK_OK) begin
            negotiation_done_o <= 1'b1; // RULE_04
        end
    end

    // ==========================================================
    // Transmit: config ordered set while negotiating, data or idle otherwise
    logic [1:0] tx_ph_r;
    logic [7:0] tx_code_nxt;
    logic tx_k_nxt;

    assign fifo_pop = !sm_rst && !an_running;

    always_comb begin
        tx_code_nxt = pcsmg_pkg::K28_5;
        tx_k_nxt = 1'b1;
        if (an_running) begin
            case (tx_ph_r)
                2'h0: begin
                    tx_code_nxt = pcsmg_pkg::K28_5;
                    tx_k_nxt = 1'b1;
                end
                2'h1: begin
                    tx_code_nxt = pcsmg_pkg::D21_5;
                    tx_k_nxt = 1'b0;
                end
                2'h2: begin
                    tx_code_nxt = local_ability_word_i[7:0]; // RULE_19
                    tx_k_nxt = 1'b0;
                end
                default: begin
                    tx_code_nxt = local_ability_word_i[15:8]; // RULE_19
                    tx_k_nxt = 1'b0;
                end
            endcase
        end else if (tx_accept && fifo_valid && fifo_out[8]) begin
            tx_code_nxt = fifo_out[7:0];
            tx_k_nxt = 1'b0;
        end else if (tx_ph_r[0]) begin
            tx_code_nxt = pcsmg_pkg::D16_2;
            tx_k_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_ph_r <= 2'h0;
            tx_code_o <= 8'h00;
            tx_kcntl_o <= 1'b0;
        end else if (sm_rst) begin
            tx_ph_r <= 2'h0;
            tx_code_o <= 8'h00;
            tx_kcntl_o <= 1'b0;
        end else begin
            tx_ph_r <= tx_ph_r + 2'h1;
            tx_code_o <= tx_code_nxt;
            tx_kcntl_o <= tx_k_nxt;
        end
    end

    // ==========================================================
    // Receive: loopback select, sync and config word capture
    logic [7:0] rx_cg;
    logic rx_k;
    logic [1:0] sync_cnt_r;

    assign rx_cg = force_loopback_i ? tx_code_o : rx_code_i; // RULE_11
    assign rx_k = force_loopback_i ? tx_kcntl_o : rx_kcntl_i; // RULE_11

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_cnt_r <= 2'h0;
            rx_sync_r <= 1'b0;
        end else if (sm_rst || (!signal_detect_i && !force_loopback_i)
                || (rx_cv_err_i && !force_loopback_i)) begin
            sync_cnt_r <= 2'h0;
            rx_sync_r <= 1'b0;
        end else if (rx_k && rx_cg == pcsmg_pkg::K28_5 && !rx_sync_r) begin
            sync_cnt_r <= sync_cnt_r + 2'h1;
            rx_sync_r <= (sync_cnt_r == 2'(pcsmg_pkg::SYNC_NEED - 1));
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_ph_r <= 2'h0;
            rx_word_r <= 16'h0000;
            rx_word_vld_r <= 1'b0;
        end else if (sm_rst) begin
            cfg_ph_r <= 2'h0;
            rx_word_r <= 16'h0000;
            rx_word_vld_r <= 1'b0;
        end else begin
            rx_word_vld_r <= 1'b0;
            case (cfg_ph_r)
                2'h0: begin
                    if (rx_k && rx_cg == pcsmg_pkg::K28_5) begin
                        cfg_ph_r <= 2'h1;
                    end
                end
                2'h1: begin
                    cfg_ph_r <= (!rx_k && (rx_cg == pcsmg_pkg::D21_5 || rx_cg == pcsmg_pkg::D2_2))
                        ? 2'h2 : 2'h0;
                end
                2'h2: begin
                    rx_word_r[7:0] <= rx_cg;
                    cfg_ph_r <= 2'h3;
                end
                default: begin
                    rx_word_r[15:8] <= rx_cg;
                    rx_word_vld_r <= 1'b1;
                    cfg_ph_r <= 2'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lp_word_r <= 16'h0000;
        end else if (sm_rst) begin
            lp_word_r <= 16'h0000;
        end else if (rx_word_vld_r && st_r == pcsmg_pkg::PCSMG_ABIL_DET) begin
            lp_word_r <= rx_word_r; // RULE_05
        end
    end
    assign partner_ability_word_o = lp_word_r;

    // Isolated outputs stay driven as zeros, never released
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gmii_rxd_o <= 8'h00;
            gmii_rx_dv_o <= 1'b0;
            gmii_rx_er_o <= 1'b0;
        end else if (force_isolate_i || sm_rst || !rx_sync_r) begin
            gmii_rxd_o <= 8'h00; // RULE_07 RULE_09
            gmii_rx_dv_o <= 1'b0;
            gmii_rx_er_o <= 1'b0;
        end else begin
            gmii_rxd_o <= rx_k ? 8'h00 : rx_cg;
            gmii_rx_dv_o <= !rx_k && !link_good_o ? 1'b0 : !rx_k;
            gmii_rx_er_o <= rx_cv_err_i && !force_loopback_i;
        end
    end

    // ==========================================================
    // Checks
    a_isolate_rx_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_07
        force_isolate_i |=> (gmii_rxd_o == 8'h00 && !gmii_rx_dv_o))
        else $error("receive output not zero under isolate");
    a_page_rx_state: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_06
        $rose(page_received_o) |-> $past(st_r) == pcsmg_pkg::PCSMG_ACK_DET)
        else $error("page received raised outside acknowledge");
    a_main_reset_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_02
        sm_rst |=> (st_r == pcsmg_pkg::PCSMG_AN_ENABLE && tx_code_o == 8'h00))
        else $error("main reset did not hold state");
    a_restart_init: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_03
        (negotiation_restart_i && negotiation_enable_i && !sm_rst)
        |=> st_r == pcsmg_pkg::PCSMG_AN_ENABLE)
        else $error("restart ignored");
    a_disable_link: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_15 RULE_01
        (!negotiation_enable_i && !sm_rst) [*2] |-> link_good_o)
        else $error("link not good when negotiation disabled");
    a_done_link_ok: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_04 RULE_14
        (st_r == pcsmg_pkg::PCSMG_LINK_OK && negotiation_enable_i && !negotiation_restart_i
        && !sm_rst) |=> negotiation_done_o)
        else $error("done not raised in link ok");
    a_idle_insert: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_18
        (st_r == pcsmg_pkg::PCSMG_ABIL_DET && negotiation_enable_i && !sm_rst)
        |-> idle_insert_o)
        else $error("idle insert low while negotiating");
    a_cfg_word_tx: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_19
        (an_running && !sm_rst && tx_ph_r == 2'h2)
        |=> tx_code_o == $past(local_ability_word_i[7:0]))
        else $error("ability word not sent");
    a_loop_path: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RULE_11
        (force_loopback_i && !force_isolate_i && !sm_rst && rx_sync_r && !tx_kcntl_o)
        |=> gmii_rxd_o == $past(tx_code_o))
        else $error("loopback path wrong");

    c_reach_link: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        st_r == pcsmg_pkg::PCSMG_LINK_OK);
    c_page_rx: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) page_received_o);
    c_isolate: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        force_isolate_i && rx_sync_r);
    c_unidir: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        force_unidir_i && rx_bad && fifo_valid);
endmodule : pcsmg_ctrl
`default_nettype wire

// *** verilog/pcsmg_pkg.sv ***
// Shared constants and types for the PCS management and test-mode control block
// Functional notes
// (RULE_01) Negotiation runs only while enable high
// (RULE_02) Main reset holds all state machines
// (RULE_03) Restart returns negotiation to initial state
// (RULE_04) Done output high after negotiation completes
// (RULE_05) Partner ability word shown on output
// (RULE_06) Page received high only in acknowledge
// (RULE_07) Isolate forces receive GMII outputs zero
// (RULE_08) Isolate makes transmit see zero inputs
// (RULE_09) Isolation logical, outputs always driven
// (RULE_10) Unused test inputs tied low outside
// (RULE_11) Loopback feeds transmit code-groups to receive
// (RULE_12) Unidirectional keeps transmit path running
// (RULE_13) Otherwise receive faults suspend transmit input
// (RULE_14) Link good in link-ok when enabled
// (RULE_15) Link good in disable-link-ok when disabled
// (RULE_16) Active-low global reset clears everything; the FIFO storage array has no reset
// (RULE_17) Debug input shortens link timer greatly
// (RULE_18) Idle insertion high while negotiating
// (RULE_19) Local ability word sent while negotiating
// (RULE_20) Normal timer per link_timer, debug small
package pcsmg_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 25000;
    localparam int LINK_TIMER_US = 10;
    localparam int LINK_TIMER_CYC = (LINK_TIMER_US * 1000000) / CLK_PERIOD_PS;
    localparam int DEBUG_TIMER_CYC = 16;
    localparam int TIMER_W = 20;

    // ==========================================================
    // Code-group constants
    localparam logic [7:0] K28_5 = 8'hbc;
    localparam logic [7:0] D21_5 = 8'hb5;
    localparam logic [7:0] D2_2 = 8'h42;
    localparam logic [7:0] D16_2 = 8'h50;
    localparam int ACK_BIT = 14;
    localparam int WORD_W = 16;
    localparam int CODE_W = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int SYNC_NEED = 3;

    // ==========================================================
    // Negotiation states
    typedef enum logic [6:0] {
        PCSMG_AN_ENABLE = 7'h01,
        PCSMG_AN_RESTART = 7'h02,
        PCSMG_ABIL_DET = 7'h04,
        PCSMG_ACK_DET = 7'h08,
        PCSMG_CMPL_ACK = 7'h10,
        PCSMG_LINK_OK = 7'h20,
        PCSMG_DIS_LINK_OK = 7'h40
    } pcsmg_an_e;

endpackage : pcsmg_pkg

// *** verilog/pcsmg_fifo.sv ***
// Small valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module pcsmg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic flush_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else if (flush_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_over: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
        cnt_r <= (AW+1)'(DEPTH)) else $error("FIFO count beyond depth");
endmodule : pcsmg_fifo
`default_nettype wire

// *** verilog/pcsmg_link_timer.sv ***
// Auto-negotiation link timer with a debug short mode
`timescale 1ns/1ps
`default_nettype none
module pcsmg_link_timer #(
    parameter int NORMAL_CYC = pcsmg_pkg::LINK_TIMER_CYC,
    parameter int DEBUG_CYC = pcsmg_pkg::DEBUG_TIMER_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic start_i,
    input wire logic short_i,
    // Status
    output logic done_o
);
    localparam int W = pcsmg_pkg::TIMER_W;
    logic [W-1:0] cnt_r;
    logic [W-1:0] limit;

    assign limit = short_i ? W'(DEBUG_CYC - 1) : W'(NORMAL_CYC - 1); // RULE_17 RULE_20
    assign done_o = (cnt_r >= limit);

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= '0;
        end else if (start_i) begin
            cnt_r <= '0;
        end else if (!done_o) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule : pcsmg_link_timer
`default_nettype wire

// *** verification/pcsmg_serdes_model.sv ***
// Code-group source standing in for the far receive side
`timescale 1ns/1ps
`default_nettype none
module pcsmg_serdes_model (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Control
    input wire logic cfg_en_i,
    input wire logic [15:0] cfg_word_i,
    input wire logic sig_loss_i,
    // Code-group stream
    output logic [7:0] rx_code_o,
    output logic rx_kcntl_o,
    output logic rx_cv_err_o,
    output logic signal_detect_o
);
    logic [1:0] phase_r;
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_r <= 2'h0;
        end else begin
            phase_r <= phase_r + 2'h1;
        end
    end
    // Config sets when enabled, idle pairs otherwise; comma always on phase 0
    always_comb begin
        rx_kcntl_o = (phase_r == 2'h0) || (!cfg_en_i && phase_r == 2'h2);
        case (phase_r)
            2'h0: rx_code_o = pcsmg_pkg::K28_5;
            2'h1: rx_code_o = cfg_en_i ? pcsmg_pkg::D21_5 : pcsmg_pkg::D16_2;
            2'h2: rx_code_o = cfg_en_i ? cfg_word_i[7:0] : pcsmg_pkg::K28_5;
            default: rx_code_o = cfg_en_i ? cfg_word_i[15:8] : pcsmg_pkg::D16_2;
        endcase
        rx_cv_err_o = 1'b0;
        signal_detect_o = !sig_loss_i;
    end
endmodule : pcsmg_serdes_model
`default_nettype wire

// *** verification/tb_pcs_mgmt_autoneg_test_control.sv ***
// Self-checking bench for the PCS management and test-mode control block
`timescale 1ns/1ps
`default_nettype none
module tb_pcs_mgmt_autoneg_test_control;
    logic clk = 1'b0, rst_b = 1'b0, en = 1'b1, mrst = 1'b0, rst_an = 1'b0;
    logic iso = 1'b0, lpb = 1'b0, uni = 1'b0, dbg = 1'b1;
    logic [15:0] law = 16'h1234, cfg_w = 16'h41a0, paw;
    logic cfg_en = 1'b1, txen = 1'b0, txer = 1'b0, sdl = 1'b0;
    logic [7:0] txd = 8'h00, rxd, txc, rxc;
    logic done, page, lgood, txrdy, rxdv, rxer, txk, rxk, cve, sd, idl;
    int n_mismatch = 0, total_checks = 0, cyc_cnt = 0, i, n;

    pcsmg_ctrl #(.LINK_CYC(200)) dut_u (.sys_clk_i(clk), .rst_b_i(rst_b),
        .negotiation_enable_i(en), .pcs_main_reset_i(mrst), .negotiation_restart_i(rst_an),
        .local_ability_word_i(law), .negotiation_done_o(done), .partner_ability_word_o(paw),
        .page_received_o(page), .link_good_o(lgood), .force_isolate_i(iso),
        .force_loopback_i(lpb), .force_unidir_i(uni), .debug_link_timer_short_i(dbg),
        .gmii_txd_i(txd), .gmii_tx_en_i(txen), .gmii_tx_er_i(txer), .gmii_tx_ready_o(txrdy),
        .gmii_rxd_o(rxd), .gmii_rx_dv_o(rxdv), .gmii_rx_er_o(rxer), .tx_code_o(txc),
        .tx_kcntl_o(txk), .rx_code_i(rxc), .rx_kcntl_i(rxk), .rx_cv_err_i(cve),
        .signal_detect_i(sd), .idle_insert_o(idl));
    pcsmg_serdes_model far_u (.sys_clk_i(clk), .rst_b_i(rst_b), .cfg_en_i(cfg_en),
        .cfg_word_i(cfg_w), .sig_loss_i(sdl), .rx_code_o(rxc), .rx_kcntl_o(rxk), .rx_cv_err_o(cve),
        .signal_detect_o(sd));

    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ==========================================================
    // Helpers
    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    task report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Scenarios
    task t_negotiate(input int tmin, input int tmax);
        for (i = 0; i < 600 && txc !== pcsmg_pkg::D21_5; i++) @(negedge clk);
        @(negedge clk);
        chk(txc, law[7:0]);
        @(negedge clk);
        chk(txc, law[15:8]);
        for (i = 0; i < 600 && page !== 1'b1; i++) @(negedge clk);
        chk(page, 1'b1);
        chk(paw, cfg_w);
        chk(lgood, 1'b0);
        for (n = 0; n < 600 && page === 1'b1; n++) @(negedge clk);
        chk(n >= tmin && n < tmax, 1'b1);
        chk(lgood, 1'b1);
        chk(idl, 1'b0);
        @(negedge clk);
        chk(done, 1'b1);
        $display("negotiation test done");
    endtask : t_negotiate
    task t_restart_fifo();
        rst_an = 1'b1;
        @(negedge clk);
        rst_an = 1'b0;
        chk({lgood, page, idl}, 3'b001);
        @(negedge clk);
        chk(done, 1'b0);
        txen = 1'b1;
        n = 0;
        for (i = 0; i < 8; i++) begin
            if (txrdy === 1'b1) n++;
            txd = 8'h60 + 8'(n);
            @(negedge clk);
        end
        chk(n, 0);
        chk(txrdy, 1'b0);
        en = 1'b0;
        @(negedge clk);
        chk({lgood, idl, page}, 3'b100);
        txen = 1'b0;
        for (i = 0; i < 50 && txrdy !== 1'b1; i++) @(negedge clk);
        chk(txrdy, 1'b1);
        sdl = 1'b1;
        txd = 8'ha7;
        txen = 1'b1;
        cyc_wait(8);
        n = 0;
        for (i = 0; i < 8; i++) begin
            if (txc === 8'ha7) n++;
            @(negedge clk);
        end
        chk(n, 0);
        uni = 1'b1;
        for (i = 0; i < 20 && txc !== 8'ha7; i++) @(negedge clk);
        chk({txk, txc}, 9'h0a7);
        uni = 1'b0;
        txen = 1'b0;
        sdl = 1'b0;
        $display("restart and buffer test done");
    endtask : t_restart_fifo
    task t_loop_isolate();
        lpb = 1'b1;
        cyc_wait(20);
        txd = 8'h5d;
        txen = 1'b1;
        for (i = 0; i < 300 && !(rxdv === 1'b1 && rxd === 8'h5d); i++) @(negedge clk);
        chk({rxdv, rxd}, 9'h15d);
        iso = 1'b1;
        cyc_wait(3);
        chk({rxdv, rxer, rxd}, 10'h000);
        cyc_wait(12);
        n = 0;
        for (i = 0; i < 8; i++) begin
            if (txc === 8'h5d) n++;
            @(negedge clk);
        end
        chk(n, 0);
        chk({rxdv, rxer, rxd}, 10'h000);
        iso = 1'b0;
        for (i = 0; i < 300 && !(rxdv === 1'b1 && rxd === 8'h5d); i++) @(negedge clk);
        chk({rxdv, rxd}, 9'h15d);
        txen = 1'b0;
        lpb = 1'b0;
        $display("loopback and isolate test done");
    endtask : t_loop_isolate
    task t_main_reset();
        mrst = 1'b1;
        cyc_wait(3);
        chk({lgood, page, done}, 3'b000);
        mrst = 1'b0;
        for (i = 0; i < 20 && lgood !== 1'b1; i++) @(negedge clk);
        chk(lgood, 1'b1);
        $display("main reset test done");
    endtask : t_main_reset
    task cyc_wait(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc_wait

    initial begin
        cyc_wait(6);
        rst_b = 1'b1;
        chk({lgood, page, done, idl}, 4'b0001);
        t_negotiate(16, 40);
        dbg = 1'b0;
        rst_an = 1'b1;
        @(negedge clk);
        rst_an = 1'b0;
        t_negotiate(200, 600);
        t_restart_fifo();
        t_loop_isolate();
        t_main_reset();
        report_and_stop();
    end
endmodule : tb_pcs_mgmt_autoneg_test_control
`default_nettype wire
